/* pkg/pei_pkg.sv */
package pei_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] EVENT_MASK_IDX = 8'h19;
   localparam logic [7:0] EVENT_PENDING_IDX = 8'h1a;
   localparam logic [7:0] CFG_IDX = 8'h1b;
   localparam logic [11:0] EVENT_MASK_ADDR = {2'h0, EVENT_MASK_IDX, 2'h0};
   localparam logic [11:0] EVENT_PENDING_ADDR = {2'h0, EVENT_PENDING_IDX, 2'h0};
   localparam logic [11:0] CFG_ADDR = {2'h0, CFG_IDX, 2'h0};
   localparam logic [15:0] EVENT_MASK_RST = 16'h0000;
   localparam logic [15:0] EVENT_PENDING_RST = 16'h0000;
   localparam logic [5:0] CFG_RST = 6'h00;
   localparam int PIN_EN_BIT = 15;
   localparam int SUMMARY_BIT = 15;
   localparam int NUM_CAUSES = 15;
   // Cause positions, bit 14 down to 0
   localparam int C_SPEED = 14;
   localparam int C_LINK = 13;
   localparam int C_DUPLEX = 12;
   localparam int C_ANEG_ERR = 11;
   localparam int C_ANEG_DONE = 10;
   localparam int C_PD_DETECT = 9;
   localparam int C_SYMBOL = 8;
   localparam int C_FAST_FAIL = 7;
   localparam int C_TX_FIFO = 6;
   localparam int C_RX_FIFO = 5;
   localparam int C_MEDIA = 4;
   localparam int C_FALSE_CARRIER = 3;
   localparam int C_DOWNSHIFT = 2;
   localparam int C_MS_ERR = 1;
   localparam int C_RX_ERR = 0;
   // Qualifier config register fields
   localparam int CFG_ANEG_EN_BIT = 0;
   localparam int CFG_FAST_FAIL_EN_BIT = 1;
   localparam int CFG_ADV_LSB = 2;
   localparam int CFG_ADV_W = 4;

   typedef struct packed {
      logic [11:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
   } pei_apb_req_t;

   typedef struct packed {
      logic aneg_en;
      logic fast_fail_en;
      logic [3:0] adv;
      logic carrier_ext;
   } pei_qual_t;
endpackage

/* core/pei_apb_slave.sv */
`timescale 1ns/1ps
// APB slave front end: single-cycle access, zero wait states
module pei_apb_slave
   import pei_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire pei_apb_req_t req,
   input wire logic [31:0] rdata_in,
   input wire logic hit,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic wr_stb,
   output logic rd_stb
);
   // Strobes fire on the access phase edge only
   assign wr_stb = psel & penable & req.pwrite & hit;
   assign rd_stb = psel & penable & ~req.pwrite & hit;

   // Registered answer during setup, ready in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= ~hit; // Unmapped addresses answer with an error
         // Writes answer with zero data so the bus never echoes a register on a write
         prdata <= (hit && !req.pwrite) ? rdata_in : 32'h0000_0000;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end
endmodule

/* core/pei_event_irq.sv */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module pei_event_irq
   import pei_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   input wire logic [14:0] event_in,
   input wire logic carrier_ext_in,
   output logic mgmt_irq_pin,
   output logic irq
);
   pei_apb_req_t req;
   logic [15:0] event_mask;
   logic [15:0] event_pending;
   logic [5:0] cfg;
   logic [14:0] ev_meta;
   logic [14:0] ev_sync;
   logic cext_meta;
   logic cext_sync;
   logic [14:0] ev_q;
   logic [14:0] ev_qual;
   logic [14:0] next_causes;
   logic next_summary;
   logic [31:0] rdata_mux;
   logic hit;
   logic wr_stb;
   logic rd_stb;
   pei_qual_t qual;

   // Decode a byte address into a hit on one of the three words
   function automatic logic addr_hit(input logic [11:0] a);
      return (a == EVENT_MASK_ADDR) || (a == EVENT_PENDING_ADDR) || (a == CFG_ADDR);
   endfunction

   assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
   assign hit = addr_hit(paddr);

   pei_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .req(req),
      .rdata_in(rdata_mux),
      .hit(hit),
      .pready(pready),
      .pslverr(pslverr),
      .prdata(prdata),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb)
   );

   // Event lines come from other logic domains; two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_meta <= 15'h0000;
         ev_sync <= 15'h0000;
         cext_meta <= 1'b0;
         cext_sync <= 1'b0;
      end else begin
         ev_meta <= event_in;
         ev_sync <= ev_meta;
         cext_meta <= carrier_ext_in;
         cext_sync <= cext_meta;
      end
   end

   // Previous level for rising-edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_q <= 15'h0000;
      end else begin
         ev_q <= ev_sync;
      end
   end

   assign qual = '{aneg_en: cfg[CFG_ANEG_EN_BIT],
                   fast_fail_en: cfg[CFG_FAST_FAIL_EN_BIT],
                   adv: cfg[CFG_ADV_LSB +: CFG_ADV_W],
                   carrier_ext: cext_sync};

   // Qualify each cause edge before it may latch
   always_comb begin
      ev_qual = ev_sync & ~ev_q;
      if (!qual.aneg_en) begin
         ev_qual[C_SPEED] = 1'b0;
         ev_qual[C_DUPLEX] = 1'b0;
      end
      if (!qual.fast_fail_en) begin
         ev_qual[C_FAST_FAIL] = 1'b0;
      end
      if (qual.adv != 4'hf) begin
         ev_qual[C_DOWNSHIFT] = 1'b0;
      end
      if (qual.carrier_ext) begin
         ev_qual[C_RX_ERR] = 1'b0;
      end
   end

   // Read clears only what was returned; a cause latched after the setup edge survives
   always_comb begin
      next_causes = event_pending[14:0];
      next_summary = event_pending[SUMMARY_BIT];
      if (rd_stb && paddr == EVENT_PENDING_ADDR) begin
         next_causes = event_pending[14:0] & ~prdata[14:0];
         next_summary = event_pending[SUMMARY_BIT] & ~prdata[SUMMARY_BIT];
      end
      next_causes = next_causes | ev_qual;
      if (|(ev_qual & event_mask[14:0])) begin
         next_summary = 1'b1;
      end
   end

   // Status register; latching ignores mask bit 15
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_pending <= EVENT_PENDING_RST;
      end else begin
         event_pending <= {next_summary, next_causes};
      end
   end

   // Mask register, software writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_mask <= EVENT_MASK_RST;
      end else if (wr_stb && paddr == EVENT_MASK_ADDR) begin
         event_mask <= pwdata[15:0];
      end
   end

   // Qualifier config: aneg enable, fast-fail enable, advertisement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= CFG_RST;
      end else if (wr_stb && paddr == CFG_ADDR) begin
         cfg <= pwdata[5:0];
      end
   end

   // Read mux; upper bits read as zero
   always_comb begin
      rdata_mux = 32'h0000_0000;
      unique case (paddr)
         EVENT_MASK_ADDR: rdata_mux = {16'h0000, event_mask};
         EVENT_PENDING_ADDR: rdata_mux = {16'h0000, event_pending};
         CFG_ADDR: rdata_mux = {26'h0000000, cfg};
         default: rdata_mux = 32'h0000_0000;
      endcase
   end

   // Pin follows summary only when enabled; registered, one cycle behind the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mgmt_irq_pin <= 1'b0;
         irq <= 1'b0;
      end else begin
         mgmt_irq_pin <= event_mask[PIN_EN_BIT] & event_pending[SUMMARY_BIT];
         irq <= event_mask[PIN_EN_BIT] & event_pending[SUMMARY_BIT];
      end
   end
endmodule

/* verif/pei_event_irq_assertions.sv */
`timescale 1ns/1ps
// Watches the bus answer and the pin from the top ports only
module pei_event_irq_chk
   import pei_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic mgmt_irq_pin,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Decoded access kinds
   wire hit = paddr == EVENT_MASK_ADDR || paddr == EVENT_PENDING_ADDR || paddr == CFG_ADDR;
   wire rd_st = pready && psel && !pwrite && paddr == EVENT_PENDING_ADDR;
   wire pin_off = pready && psel && pwrite && paddr == EVENT_MASK_ADDR && !pwdata[PIN_EN_BIT];
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   ready_single_a: assert property (pready |=> !pready) else $error("ready held");
   unmapped_err_a: assert property (psel && !penable && !hit |=> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   mapped_ok_a: assert property (psel && !penable && hit |=> !pslverr)
      else $error("mapped refused");
   idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
   upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper set");
   irq_match_a: assert property (irq == mgmt_irq_pin) else $error("irq differs");
   pin_off_a: assert property (pin_off |-> ##2 !mgmt_irq_pin) else $error("pin stays");
   pin_flag_a: assert property (rd_st && mgmt_irq_pin |-> prdata[SUMMARY_BIT])
      else $error("pin without flag");
   // Main scenarios reached
   cover property (rd_st && prdata[SUMMARY_BIT]);
   cover property (pslverr);
   cover property ($rose(mgmt_irq_pin));
endmodule
bind pei_event_irq pei_event_irq_chk u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .mgmt_irq_pin(mgmt_irq_pin), .irq(irq));

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
   import pei_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, carrier_ext_in = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [14:0] event_in = 15'h0, m;
   logic pready, pslverr, mgmt_irq_pin, irq;
   logic [32:0] expq[$];
   logic [15:0] lfsr = 16'h0037;
   int err_count = 0, checks_done = 0;
   always #2.5 pclk = ~pclk;
   pei_event_irq u_pei_event_irq(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .event_in(event_in),
      .carrier_ext_in(carrier_ext_in), .mgmt_irq_pin(mgmt_irq_pin), .irq(irq));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      checks_done++;
      if (seen !== want) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One transfer; an idle cycle after it keeps drives one per time step
   task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d,
                      input logic [32:0] e);
      expq.push_back(e);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Cause levels rise, then fall; latching takes three edges
   task automatic fire(input logic [14:0] c);
      event_in <= c;
      repeat (3) @(posedge pclk);
      event_in <= 15'h0;
      repeat (6) @(posedge pclk);
   endtask
   // Compares every answer with the oldest note
   always @(posedge pclk) begin
      if (pready === 1'b1) check({pslverr, prdata}, expq.pop_front());
   end
   initial begin
      #20000;
      err_count++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(EVENT_MASK_ADDR, 0, 16'h0, {17'h0, EVENT_MASK_RST});
      apb(EVENT_PENDING_ADDR, 0, 16'h0, {17'h0, EVENT_PENDING_RST});
      apb(12'h070, 1, 16'hffff, {1'b1, 32'h0});
      apb(CFG_ADDR, 1, 16'h003f, 33'h0);
      apb(EVENT_MASK_ADDR, 1, 16'h7fff, 33'h0);
      apb(EVENT_MASK_ADDR, 0, 16'h0, 33'h7fff);
      // Each cause alone, pin disabled throughout
      for (int i = 0; i < NUM_CAUSES; i++) begin
         fire(15'h1 << i);
         check({32'h0, mgmt_irq_pin}, 33'h0);
         apb(EVENT_PENDING_ADDR, 0, 16'h0, {17'h0, 16'h8000 | (16'h1 << i)});
         apb(EVENT_PENDING_ADDR, 0, 16'h0, 33'h0);
      end
      // Qualifiers off, one advertisement bit missing, carrier extension on
      apb(CFG_ADDR, 1, 16'h001c, 33'h0);
      carrier_ext_in <= 1'b1;
      fire(15'h7fff);
      apb(EVENT_PENDING_ADDR, 0, 16'h0, {17'h0, 16'haf7a});
      carrier_ext_in <= 1'b0;
      apb(CFG_ADDR, 1, 16'h003f, 33'h0);
      // Cause whose mask bit is clear must not raise the summary
      apb(EVENT_MASK_ADDR, 1, 16'h8000, 33'h0);
      fire(15'h0010);
      check({32'h0, mgmt_irq_pin}, 33'h0);
      apb(EVENT_PENDING_ADDR, 0, 16'h0, {17'h0, 16'h0010});
      // Random causes with the pin enabled, then disabled
      for (int k = 0; k < 4; k++) begin
         lfsr = nx(lfsr);
         m = lfsr[14:0] | 15'h1;
         apb(EVENT_MASK_ADDR, 1, 16'hffff, 33'h0);
         apb(EVENT_PENDING_ADDR, 0, 16'h0, 33'h0);
         fire(m);
         check({32'h0, irq}, 33'h1);
         apb(EVENT_MASK_ADDR, 1, 16'h7fff, 33'h0);
         apb(EVENT_PENDING_ADDR, 0, 16'h0, {17'h0, 1'b1, m});
         check({32'h0, mgmt_irq_pin}, 33'h0);
      end
      final_report();
   end
endmodule
